// ### logic/wwd_pkg.sv
`default_nettype none
package wwd_pkg;
   localparam logic [11:0] WWD_OFS_RELOAD = 12'h000;
   localparam logic [11:0] WWD_OFS_MODE0 = 12'h004;
   localparam logic [11:0] WWD_OFS_MODE1 = 12'h008;
   localparam logic [11:0] WWD_OFS_STATUS = 12'h00c;
   localparam logic [11:0] WWD_OFS_PROT = 12'h010;
   localparam logic [11:0] WWD_OFS_CKSEL = 12'h018;
   localparam logic [31:0] WWD_RST_RELOAD = 32'h0000_0000;
   localparam logic [31:0] WWD_RST_MODE0 = 32'h0000_0fff;
   localparam logic [31:0] WWD_RST_MODE1 = 32'h0000_7fff;
   localparam logic [31:0] WWD_RST_STATUS = 32'h0000_0000;
   localparam logic [31:0] WWD_RST_PROT = 32'h0000_0000;
   localparam logic [31:0] WWD_RST_CKSEL = 32'h0000_0000;
   localparam logic [15:0] WWD_RELOAD_KEY = 16'h5fa0;
   localparam logic [15:0] WWD_UNLOCK_KEY = 16'h35ca;
   localparam int WWD_KEY_LSB = 16;
   localparam int WWD_STROBE_BIT = 0;
   localparam int WWD_EN_BIT = 16;
   localparam int WWD_SHLT_LSB = 14;
   localparam int WWD_RSTEN_BIT = 13;
   localparam int WWD_PSC_LSB = 12;
   localparam int WWD_ERR_BIT = 1;
   localparam int WWD_UF_BIT = 0;
   localparam logic [1:0] WWD_SLEEP_NONE = 2'h0;
   localparam logic [1:0] WWD_SLEEP_LIGHT = 2'h1;
   localparam logic [1:0] WWD_SLEEP_DEEP1 = 2'h2;
   localparam logic [1:0] WWD_SLEEP_DEEP2 = 2'h3;
endpackage
`default_nettype wire

// ### logic/wwd_regs.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: Reload control register at 0x000, write-only, resets to zero.
// RULE2: Keyed reload write loads counter with reload value; zero strobe does nothing.
// RULE3: Reload key 0x5FA0 must accompany the strobe, else whole write discarded.
// RULE4: Mode register 0 at 0x004 resets to 0x0FFF.
// RULE5: Mode register 1 at 0x008 holds delta and prescaler, resets 0x7FFF.
// RULE6: Status register at 0x00C holds error and underflow flags, resets zero.
// RULE7: Protection register at 0x010 resets zero, protection off.
// RULE8: Clock select register at 0x018 resets zero.
// RULE9: Light sleep follows halt field; deepest sleep always stops, count kept.
// RULE10: Reload above delta sets error flag and optional reset; delta>=reload disables.
// RULE11: Flags cleared by writing one, and by system reset.
// RULE12: Writing 0x35CA unlocks configuration; other values lock; bit 0 shows lock.
// RULE13: Clearing run enable restores default count; setting it loads and starts.
// RULE14: Reaching zero while running sets underflow and optional reset request.
module wwd_regs
   import wwd_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic tick_in,
   input wire logic [1:0] sleep_mode,
   input wire logic sel,
   input wire logic wr,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata,
   output logic wdt_reset_req,
   output logic [11:0] count_value
);
   logic tick_s1, tick_s2, tick_s3;
   logic [31:0] mode0, mode1, cksel;
   logic locked, err_flag, uf_flag, rst_req, running;
   logic [11:0] count;
   logic [6:0] psc;
   logic [31:0] next_mode0, next_mode1, next_cksel;
   logic next_locked, next_err_flag, next_uf_flag, next_rst_req, next_running;
   logic [11:0] next_count;
   logic [6:0] next_psc;
   logic wr_ctrl, reload_ok, halt, tick_edge, step, early, uf_event;
   logic [2:0] psc_sel;
   logic [6:0] psc_lim;

   // Tick pin: two flops to cross in, a third to find the rising edge
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tick_s1 <= 1'b0;
         tick_s2 <= 1'b0;
         tick_s3 <= 1'b0;
      end else begin
         tick_s1 <= tick_in;
         tick_s2 <= tick_s1;
         tick_s3 <= tick_s2;
      end
   end

   assign tick_edge = tick_s2 && !tick_s3;
   assign wr_ctrl = sel && wr && (addr == WWD_OFS_RELOAD); // [RULE1]
   assign reload_ok = wr_ctrl && wdata[WWD_STROBE_BIT]
      && (wdata[WWD_KEY_LSB +: 16] == WWD_RELOAD_KEY); // [RULE2] [RULE3]
   assign psc_sel = mode1[WWD_PSC_LSB +: 3];
   assign psc_lim = 7'((8'h01 << psc_sel) - 8'h01);

   always_comb begin
      halt = 1'b0;
      unique case (sleep_mode) // [RULE9]
         WWD_SLEEP_NONE: halt = 1'b0;
         WWD_SLEEP_LIGHT: halt = mode0[WWD_SHLT_LSB +: 2] == 2'h1
            || mode0[WWD_SHLT_LSB + 1];
         WWD_SLEEP_DEEP1: halt = mode0[WWD_SHLT_LSB + 1];
         WWD_SLEEP_DEEP2: halt = 1'b1;
      endcase
   end

   assign step = running && tick_edge && !halt && (psc >= psc_lim);
   assign early = reload_ok && running && (mode1[11:0] < mode0[11:0])
      && (count > mode1[11:0]); // [RULE10]
   assign uf_event = step && (count == 12'h001); // [RULE14]

   always_comb begin
      next_mode0 = mode0;
      next_mode1 = mode1;
      next_cksel = cksel;
      next_locked = locked;
      next_err_flag = err_flag;
      next_uf_flag = uf_flag;
      next_rst_req = rst_req;
      next_running = running;
      next_count = count;
      next_psc = psc;
      if (sel && wr) begin
         if (addr == WWD_OFS_PROT) begin
            next_locked = wdata[15:0] != WWD_UNLOCK_KEY; // [RULE12]
         end
         if (addr == WWD_OFS_MODE0 && !locked) begin
            next_mode0 = wdata & 32'h0001_efff; // [RULE4]
         end
         if (addr == WWD_OFS_MODE0 && locked) begin
            next_mode0[WWD_EN_BIT] = wdata[WWD_EN_BIT];
            next_mode0[WWD_SHLT_LSB +: 2] = wdata[WWD_SHLT_LSB +: 2];
         end
         if (addr == WWD_OFS_MODE1 && !locked) begin
            next_mode1 = wdata & 32'h0000_7fff; // [RULE5]
         end
         if (addr == WWD_OFS_CKSEL) begin
            next_cksel = wdata & 32'h0000_0001; // [RULE8]
         end
         if (addr == WWD_OFS_STATUS) begin
            if (wdata[WWD_ERR_BIT]) begin
               next_err_flag = 1'b0; // [RULE11]
            end
            if (wdata[WWD_UF_BIT]) begin
               next_uf_flag = 1'b0; // [RULE11]
            end
         end
      end
      if (next_mode0[WWD_EN_BIT] && !mode0[WWD_EN_BIT]) begin
         next_running = 1'b1; // [RULE13]
         next_count = next_mode0[11:0];
         next_psc = 7'h00;
      end else if (!next_mode0[WWD_EN_BIT]) begin
         next_running = 1'b0; // [RULE13]
         next_count = WWD_RST_MODE0[11:0];
         next_psc = 7'h00;
      end else if (reload_ok) begin
         next_count = mode0[11:0]; // [RULE2]
         next_psc = 7'h00;
      end else if (tick_edge && running && !halt) begin
         next_psc = (psc >= psc_lim) ? 7'h00 : 7'(psc + 7'h01);
         if (step && count != 12'h000) begin
            next_count = 12'(count - 12'h001);
         end
      end
      if (early) begin
         next_err_flag = 1'b1; // [RULE10]
      end
      if (uf_event) begin
         next_uf_flag = 1'b1; // [RULE14]
      end
      if ((early || uf_event) && mode0[WWD_RSTEN_BIT]) begin
         next_rst_req = 1'b1; // [RULE10] [RULE14]
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         mode0 <= WWD_RST_MODE0; // [RULE4]
         mode1 <= WWD_RST_MODE1; // [RULE5]
         cksel <= WWD_RST_CKSEL; // [RULE8]
         locked <= WWD_RST_PROT[0]; // [RULE7]
         err_flag <= WWD_RST_STATUS[WWD_ERR_BIT]; // [RULE6] [RULE11]
         uf_flag <= WWD_RST_STATUS[WWD_UF_BIT]; // [RULE6] [RULE11]
         rst_req <= 1'b0;
         running <= 1'b0;
         count <= WWD_RST_MODE0[11:0];
         psc <= 7'h00;
      end else begin
         mode0 <= next_mode0;
         mode1 <= next_mode1;
         cksel <= next_cksel;
         locked <= next_locked;
         err_flag <= next_err_flag;
         uf_flag <= next_uf_flag;
         rst_req <= next_rst_req;
         running <= next_running;
         count <= next_count;
         psc <= next_psc;
      end
   end

   always_comb begin
      rdata = 32'h0000_0000;
      if (sel && !wr) begin
         unique case (addr)
            WWD_OFS_MODE0: rdata = mode0;
            WWD_OFS_MODE1: rdata = mode1;
            WWD_OFS_STATUS: rdata = {30'h0, err_flag, uf_flag}; // [RULE6]
            WWD_OFS_PROT: rdata = {31'h0, locked}; // [RULE12]
            WWD_OFS_CKSEL: rdata = cksel;
            default: rdata = 32'h0000_0000; // [RULE1]
         endcase
      end
   end

   assign wdt_reset_req = rst_req;
   assign count_value = count;

   property p_reload_loads; // [RULE2]
      @(posedge clk) disable iff (!resetn)
         reload_ok && mode0[WWD_EN_BIT] && running && (sel && wr)
         |=> count == $past(mode0[11:0]);
   endproperty
   a_reload_loads: assert property (p_reload_loads) else $error("reload missed"); // [RULE2]

   property p_bad_key; // [RULE3]
      @(posedge clk) disable iff (!resetn)
         wr_ctrl && wdata[WWD_KEY_LSB +: 16] != WWD_RELOAD_KEY && running && !step
         && mode0[WWD_EN_BIT] |=> $stable(count);
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("bad key reloaded"); // [RULE3]

   property p_early_err; // [RULE10]
      @(posedge clk) disable iff (!resetn)
         early |=> err_flag && (rst_req == ($past(mode0[WWD_RSTEN_BIT]) || $past(rst_req)));
   endproperty
   a_early_err: assert property (p_early_err) else $error("early reload not flagged"); // [RULE10]

   property p_uf; // [RULE14]
      @(posedge clk) disable iff (!resetn)
         uf_event |=> uf_flag && count == 12'h000;
   endproperty
   a_uf: assert property (p_uf) else $error("underflow not flagged"); // [RULE14]

   property p_lock; // [RULE12]
      @(posedge clk) disable iff (!resetn)
         sel && wr && addr == WWD_OFS_PROT
         |=> locked == ($past(wdata[15:0]) != WWD_UNLOCK_KEY);
   endproperty
   a_lock: assert property (p_lock) else $error("lock state wrong"); // [RULE12]

   property p_deep2; // [RULE9]
      @(posedge clk) disable iff (!resetn)
         sleep_mode == WWD_SLEEP_DEEP2 && $past(sleep_mode) == WWD_SLEEP_DEEP2
         && mode0[WWD_EN_BIT] && $past(mode0[WWD_EN_BIT]) && !$past(reload_ok)
         |-> $stable(count);
   endproperty
   a_deep2: assert property (p_deep2) else $error("count moved in deep sleep"); // [RULE9]

   property p_disable; // [RULE13]
      @(posedge clk) disable iff (!resetn)
         !mode0[WWD_EN_BIT] |-> !running && count == WWD_RST_MODE0[11:0];
   endproperty
   a_disable: assert property (p_disable) else $error("disabled counter not default"); // [RULE13]

   property p_w1c; // [RULE11]
      @(posedge clk) disable iff (!resetn)
         sel && wr && addr == WWD_OFS_STATUS && wdata[WWD_UF_BIT] && !uf_event |=> !uf_flag;
   endproperty
   a_w1c: assert property (p_w1c) else $error("underflow flag not cleared"); // [RULE11]

   property p_err_w1c; // [RULE11]
      @(posedge clk) disable iff (!resetn)
         sel && wr && addr == WWD_OFS_STATUS && wdata[WWD_ERR_BIT] && !early
         |=> !err_flag;
   endproperty
   a_err_w1c: assert property (p_err_w1c) else $error("error flag not cleared"); // [RULE11]

   property p_strobe_zero; // [RULE2]
      @(posedge clk) disable iff (!resetn)
         wr_ctrl && !wdata[WWD_STROBE_BIT] && running && !step |=> $stable(count);
   endproperty
   a_strobe_zero: assert property (p_strobe_zero) else $error("zero strobe acted"); // [RULE2]

   property p_en_start; // [RULE13]
      @(posedge clk) disable iff (!resetn)
         $rose(mode0[WWD_EN_BIT]) |-> running && count == mode0[11:0];
   endproperty
   a_en_start: assert property (p_en_start) else $error("enable missed load"); // [RULE13]

   property p_rst_mode0; // [RULE4]
      @(posedge clk) disable iff (!resetn)
         !$past(resetn) |-> mode0 == WWD_RST_MODE0 && count == WWD_RST_MODE0[11:0];
   endproperty
   a_rst_mode0: assert property (p_rst_mode0) else $error("mode 0 reset wrong"); // [RULE4]

   property p_rst_mode1; // [RULE5]
      @(posedge clk) disable iff (!resetn)
         !$past(resetn) |-> mode1 == WWD_RST_MODE1;
   endproperty
   a_rst_mode1: assert property (p_rst_mode1) else $error("mode 1 reset wrong"); // [RULE5]

   property p_rst_status; // [RULE6]
      @(posedge clk) disable iff (!resetn)
         !$past(resetn) |-> {err_flag, uf_flag} == WWD_RST_STATUS[1:0] && !rst_req;
   endproperty
   a_rst_status: assert property (p_rst_status) else $error("status reset wrong"); // [RULE6]

   property p_rst_prot; // [RULE7]
      @(posedge clk) disable iff (!resetn)
         !$past(resetn) |-> locked == WWD_RST_PROT[0];
   endproperty
   a_rst_prot: assert property (p_rst_prot) else $error("protection reset wrong"); // [RULE7]

   property p_rst_cksel; // [RULE8]
      @(posedge clk) disable iff (!resetn)
         !$past(resetn) |-> cksel == WWD_RST_CKSEL;
   endproperty
   a_rst_cksel: assert property (p_rst_cksel) else $error("clock select reset wrong"); // [RULE8]

   property p_read_ctrl; // [RULE1]
      @(posedge clk) disable iff (!resetn)
         sel && !wr && addr == WWD_OFS_RELOAD |-> rdata == 32'h0000_0000;
   endproperty
   a_read_ctrl: assert property (p_read_ctrl) else $error("reload register readable"); // [RULE1]

   property p_halt_deep1; // [RULE9]
      @(posedge clk) disable iff (!resetn)
         sleep_mode == WWD_SLEEP_DEEP1 && mode0[WWD_SHLT_LSB + 1] && !(sel && wr)
         |=> $stable(count);
   endproperty
   a_halt_deep1: assert property (p_halt_deep1) else $error("count moved while halted"); // [RULE9]

   property p_lock_mode1; // [RULE12]
      @(posedge clk) disable iff (!resetn)
         locked && sel && wr && addr == WWD_OFS_MODE1 |=> $stable(mode1);
   endproperty
   a_lock_mode1: assert property (p_lock_mode1) else $error("locked mode 1 written"); // [RULE12]
endmodule // wwd_regs
`default_nettype wire

// ### tb/tb_window_watchdog_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_window_watchdog_regs;
   import wwd_pkg::*;
   logic clk, resetn, tick_in, sel, wr;
   logic [1:0] sleep_mode;
   logic [11:0] addr, count_value, held;
   logic [31:0] wdata, rdata;
   logic wdt_reset_req;
   int n_mismatch = 0;
   int cmp_count = 0;
   wwd_regs DUT (.clk(clk), .resetn(resetn), .tick_in(tick_in), .sleep_mode(sleep_mode),
      .sel(sel), .wr(wr), .addr(addr), .wdata(wdata), .rdata(rdata),
      .wdt_reset_req(wdt_reset_req), .count_value(count_value));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic wreg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      #1 sel = 1'b1;
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clk);
      #1 sel = 1'b0;
      wr = 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      #1 sel = 1'b1;
      addr = a;
      #5 chk("rdata", e, rdata);
      @(posedge clk);
      #1 sel = 1'b0;
   endtask
   // One count tick through the pin synchroniser
   task automatic tick();
      tick_in = 1'b1;
      repeat (4) @(posedge clk);
      #1 tick_in = 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic t_reset_values();
      rchk(WWD_OFS_RELOAD, 32'h0000_0000);
      rchk(WWD_OFS_MODE0, 32'h0000_0fff);
      rchk(WWD_OFS_MODE1, 32'h0000_7fff);
      rchk(WWD_OFS_STATUS, 32'h0000_0000);
      rchk(WWD_OFS_PROT, 32'h0000_0000);
      rchk(WWD_OFS_CKSEL, 32'h0000_0000);
      rchk(12'h014, 32'h0000_0000);
      wreg(WWD_OFS_CKSEL, 32'h0000_0001);
      rchk(WWD_OFS_CKSEL, 32'h0000_0001);
   endtask
   task automatic t_protect();
      wreg(WWD_OFS_PROT, 32'h0000_1234);
      rchk(WWD_OFS_PROT, 32'h0000_0001);
      wreg(WWD_OFS_MODE1, 32'h0000_0123);
      rchk(WWD_OFS_MODE1, 32'h0000_7fff);
      wreg(WWD_OFS_PROT, 32'h0000_35ca);
      rchk(WWD_OFS_PROT, 32'h0000_0000);
   endtask
   task automatic t_reload();
      wreg(WWD_OFS_MODE0, 32'h0000_0020);
      wreg(WWD_OFS_MODE0, 32'h0001_0020);
      settle();
      chk("count", 12'h020, count_value);
      wreg(WWD_OFS_MODE0, 32'h0001_0030);
      settle();
      held = count_value;
      wreg(WWD_OFS_RELOAD, 32'h1234_0001);
      wreg(WWD_OFS_RELOAD, 32'h5fa0_0000);
      settle();
      chk("count", held, count_value);
      wreg(WWD_OFS_RELOAD, 32'h5fa0_0001);
      settle();
      chk("count", 12'h030, count_value);
      rchk(WWD_OFS_STATUS, 32'h0000_0000);
   endtask
   task automatic t_early_error();
      wreg(WWD_OFS_MODE1, 32'h0000_0005);
      wreg(WWD_OFS_RELOAD, 32'h5fa0_0001);
      settle();
      rchk(WWD_OFS_STATUS, 32'h0000_0002);
      chk("reset_req", 1'b0, wdt_reset_req);
      wreg(WWD_OFS_STATUS, 32'h0000_0002);
      rchk(WWD_OFS_STATUS, 32'h0000_0000);
   endtask
   task automatic t_sleep_enable();
      sleep_mode = WWD_SLEEP_DEEP2;
      tick();
      settle();
      chk("count", 12'h030, count_value);
      sleep_mode = WWD_SLEEP_LIGHT;
      tick();
      settle();
      chk("count", 12'h02f, count_value);
      sleep_mode = WWD_SLEEP_NONE;
      wreg(WWD_OFS_MODE0, 32'h0000_0030);
      settle();
      chk("count", 12'hfff, count_value);
   endtask
   task automatic t_halt_prescale();
      wreg(WWD_OFS_MODE1, 32'h0000_1fff);
      wreg(WWD_OFS_MODE0, 32'h0001_4010);
      sleep_mode = WWD_SLEEP_DEEP1;
      tick();
      chk("count", 12'h010, count_value);
      tick();
      chk("count", 12'h00f, count_value);
      sleep_mode = WWD_SLEEP_LIGHT;
      tick();
      tick();
      chk("count", 12'h00f, count_value);
      wreg(WWD_OFS_PROT, 32'h0000_0000);
      wreg(WWD_OFS_MODE0, 32'h0001_8000);
      rchk(WWD_OFS_MODE0, 32'h0001_8010);
      sleep_mode = WWD_SLEEP_DEEP1;
      tick();
      tick();
      chk("count", 12'h00f, count_value);
      wreg(WWD_OFS_MODE1, 32'h0000_0000);
      rchk(WWD_OFS_MODE1, 32'h0000_1fff);
      wreg(WWD_OFS_PROT, 32'h0000_35ca);
      sleep_mode = WWD_SLEEP_NONE;
      wreg(WWD_OFS_MODE0, 32'h0001_0001);
      wreg(WWD_OFS_RELOAD, 32'h5fa0_0001);
      tick();
      tick();
      chk("count", 12'h000, count_value);
      chk("reset_req", 1'b0, wdt_reset_req);
      rchk(WWD_OFS_STATUS, 32'h0000_0001);
      wreg(WWD_OFS_STATUS, 32'h0000_0001);
      rchk(WWD_OFS_STATUS, 32'h0000_0000);
      wreg(WWD_OFS_MODE0, 32'h0000_0000);
      chk("count", 12'hfff, count_value);
   endtask
   task automatic t_underflow();
      wreg(WWD_OFS_MODE1, 32'h0000_0fff);
      wreg(WWD_OFS_MODE0, 32'h0001_2003);
      settle();
      chk("count", 12'h003, count_value);
      repeat (3) tick();
      settle();
      chk("count", 12'h000, count_value);
      chk("reset_req", 1'b1, wdt_reset_req);
      rchk(WWD_OFS_STATUS, 32'h0000_0001);
      wreg(WWD_OFS_STATUS, 32'h0000_0002);
      rchk(WWD_OFS_STATUS, 32'h0000_0001);
      resetn = 1'b0;
      repeat (2) @(posedge clk);
      #1 resetn = 1'b1;
      chk("reset_req", 1'b0, wdt_reset_req);
      rchk(WWD_OFS_STATUS, 32'h0000_0000);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      resetn = 1'b0;
      tick_in = 1'b0;
      sleep_mode = WWD_SLEEP_NONE;
      sel = 1'b0;
      wr = 1'b0;
      addr = 12'h000;
      wdata = 32'h0000_0000;
      repeat (12) @(posedge clk);
      #1 resetn = 1'b1;
      chk("count", 12'hfff, count_value);
      t_reset_values();
      t_protect();
      t_reload();
      t_early_error();
      t_sleep_enable();
      t_halt_prescale();
      t_underflow();
      report_and_stop();
   end
endmodule // tb_window_watchdog_regs
`default_nettype wire
